/* design/afsm_monitor.sv */
/*
 * Fault-status monitor for an amplifier output stage. Samples the wired-OR
 * open-drain warning and shutdown lines, decodes the condition and flags
 * shutdown edges as fault and recovery events.
 * Assumes pull-ups on both lines; stages run in auto-recovery mode.
 */
`timescale 1ns/10ps
module afsm_monitor #(
    parameter int SYNC_STAGES = afsm_pkg::AFSM_SYNC_STAGES
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 clkEn,
    input  wire logic                 overtemp_warning_n,
    input  wire logic                 shutdown_fault_n,
    output logic                      stage_mode_sel0,
    output logic                      stage_mode_sel1,
    output logic                      stage_mode_sel2,
    output afsm_pkg::afsm_status_type status,
    output logic                      statusValid
);
    // Refuse a depth the 2-bit warm-up counter cannot serve
    if (SYNC_STAGES < 2 || SYNC_STAGES > 4) begin : gBadDepth
        $error("afsm_monitor: SYNC_STAGES outside 2 to 4");
    end

    // Decode of the two active-low lines
    function automatic afsm_pkg::afsm_cond_type decodeCond(
        input logic warnN,
        input logic shutN
    );
        afsm_pkg::afsm_cond_type c;
        c = afsm_pkg::AFSM_NORMAL;
        case ({warnN, shutN})
            2'h0:    c = afsm_pkg::AFSM_ERROR;
            2'h1:    c = afsm_pkg::AFSM_WARNING;
            2'h2:    c = afsm_pkg::AFSM_UVLO;
            default: c = afsm_pkg::AFSM_NORMAL;
        endcase
        return c;
    endfunction : decodeCond

    // Synchroniser warm-up states
    typedef enum logic [1:0] {
        WARMUP,
        RUNNING
    } afsm_phase_type;

    typedef struct packed {
        afsm_phase_type            phase;    // Warm-up or running
        logic [1:0]                fill;     // Warm-up cycle count
        logic                      shutPrev; // Previous shutdown level
        afsm_pkg::afsm_status_type stat;     // Reported status
        logic                      valid;    // Status is trustworthy
    } afsm_state_type;

    afsm_state_type state_q;   // Registered state
    afsm_state_type state_d;   // Next state

    logic [1:0] lineSync;      // Synchronised lines

    // One synchroniser per open-drain line; pull-up idle is high
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gSync
            afsm_sync #(
                .STAGES    (SYNC_STAGES),
                .RESET_VAL (afsm_pkg::AFSM_LINE_IDLE)
            ) uSync (
                .sys_clk (sys_clk),
                .rst     (rst),
                .clkEn   (clkEn),
                .asyncIn ((g == afsm_pkg::AFSM_BIT_WARN) ?
                          overtemp_warning_n : shutdown_fault_n),
                .syncOut (lineSync[g])
            );
        end
    endgenerate

    // Next-state logic
    always_comb begin
        state_d = state_q;
        state_d.stat.recovered  = 1'h0;
        state_d.stat.faultEvent = 1'h0;
        if (clkEn) begin
            state_d.shutPrev = lineSync[afsm_pkg::AFSM_BIT_SHUT];
            // Decode each enabled cycle from synchronised lines only
            state_d.stat.cond = decodeCond(
                lineSync[afsm_pkg::AFSM_BIT_WARN],
                lineSync[afsm_pkg::AFSM_BIT_SHUT]);
            case (state_q.phase)
                // Wait until reset values have flushed out
                WARMUP: begin
                    state_d.fill = state_q.fill + 2'h1;
                    if (state_q.fill == 2'(SYNC_STAGES - 1)) begin
                        state_d.phase = RUNNING;
                        state_d.valid = 1'h1;
                    end
                end
                // Shutdown edges: fault then self-restart
                RUNNING: begin
                    if (state_q.shutPrev &&
                        !lineSync[afsm_pkg::AFSM_BIT_SHUT]) begin
                        state_d.stat.faultEvent = 1'h1;
                    end
                    if (!state_q.shutPrev &&
                        lineSync[afsm_pkg::AFSM_BIT_SHUT]) begin
                        state_d.stat.recovered = 1'h1;
                    end
                end
                default: begin
                    state_d.phase = WARMUP;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= '{phase: WARMUP, fill: 2'h0,
                         shutPrev: afsm_pkg::AFSM_LINE_IDLE,
                         stat: '{cond: afsm_pkg::AFSM_NORMAL,
                                 recovered: 1'h0, faultEvent: 1'h0},
                         valid: 1'h0};
        end else begin
            state_q <= state_d;
        end
    end

    // Auto-recovery mode: all selects low, constant
    assign stage_mode_sel0 = afsm_pkg::AFSM_MODE_SEL_LEVEL;
    assign stage_mode_sel1 = afsm_pkg::AFSM_MODE_SEL_LEVEL;
    assign stage_mode_sel2 = afsm_pkg::AFSM_MODE_SEL_LEVEL;
    assign status          = state_q.stat;
    assign statusValid     = state_q.valid;

    // Both lines low decode to error one cycle later
    a_error_decode: assert property (
        @(posedge sys_clk) disable iff (rst)
        clkEn && !lineSync[0] && !lineSync[1]
        |=> status.cond == afsm_pkg::AFSM_ERROR)
        else $error("error not decoded");

    // Warning low alone decodes to warning
    a_warn_decode: assert property (
        @(posedge sys_clk) disable iff (rst)
        clkEn && !lineSync[0] && lineSync[1]
        |=> status.cond == afsm_pkg::AFSM_WARNING)
        else $error("warning not decoded");

    // Shutdown low alone decodes to undervoltage or current error
    a_uvlo_decode: assert property (
        @(posedge sys_clk) disable iff (rst)
        clkEn && lineSync[0] && !lineSync[1]
        |=> status.cond == afsm_pkg::AFSM_UVLO)
        else $error("undervoltage not decoded");

    // Both lines high decode to normal
    a_normal_decode: assert property (
        @(posedge sys_clk) disable iff (rst)
        clkEn && lineSync[0] && lineSync[1]
        |=> status.cond == afsm_pkg::AFSM_NORMAL)
        else $error("normal not decoded");

    // Mode selects stay low, reset or not
    a_mode_low: assert property (
        @(posedge sys_clk)
        !stage_mode_sel0 && !stage_mode_sel1 && !stage_mode_sel2)
        else $error("mode select not low");

    // Recovery only when running, with shutdown released
    a_recover_pulse: assert property (
        @(posedge sys_clk) disable iff (rst)
        status.recovered |-> $past(statusValid)
        && status.cond != afsm_pkg::AFSM_ERROR
        && status.cond != afsm_pkg::AFSM_UVLO)
        else $error("recovery without shutdown release");

    // Recovery pulse follows a rising synchronised shutdown
    a_recover_edge: assert property (
        @(posedge sys_clk) disable iff (rst)
        status.recovered |-> $past(lineSync[1]) && !$past(state_q.shutPrev))
        else $error("recovery without rising shutdown");

    // One shutdown edge can never give both pulses
    a_pulse_apart: assert property (
        @(posedge sys_clk) disable iff (rst)
        !(status.faultEvent && status.recovered))
        else $error("fault and recovery together");

    // Reset values still in the chain must not raise edge pulses
    a_warmup_quiet: assert property (
        @(posedge sys_clk) disable iff (rst)
        !statusValid |-> !status.faultEvent && !status.recovered)
        else $error("edge reported during warm-up");

    // Valid stays up until the next reset
    a_valid_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        statusValid |=> statusValid)
        else $error("status valid dropped");

    // Low clock enable freezes the reported condition
    a_freeze_cond: assert property (
        @(posedge sys_clk) disable iff (rst)
        !clkEn |=> $stable(status.cond))
        else $error("condition moved while frozen");

    // Pins low three enabled cycles reach error on time (two stages)
    a_sync_latency: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clkEn && !overtemp_warning_n && !shutdown_fault_n) [*3]
        |=> status.cond == afsm_pkg::AFSM_ERROR)
        else $error("synchronised decode late");

    // Shutdown pin low alone, three enabled cycles, reaches undervoltage
    a_uvlo_latency: assert property (
        @(posedge sys_clk) disable iff (rst)
        (clkEn && overtemp_warning_n && !shutdown_fault_n) [*3]
        |=> status.cond == afsm_pkg::AFSM_UVLO)
        else $error("undervoltage decode late");

    // Fault pulse follows a falling synchronised shutdown
    a_fault_pulse: assert property (
        @(posedge sys_clk) disable iff (rst)
        status.faultEvent |-> !$past(lineSync[1]) && $past(state_q.shutPrev))
        else $error("fault event without falling shutdown");
endmodule : afsm_monitor

/* inc/afsm_pkg.sv */
/*
 * Package for the amplifier fault-status monitor: condition codes, mode-select
 * drive values, synchroniser depth and the carried status struct.
 * Assumes one 250 MHz clock and synchronous active-high reset.
 */
package afsm_pkg;

    // Decoded output-stage condition
    typedef enum logic [1:0] {
        AFSM_NORMAL  = 2'h0,
        AFSM_WARNING = 2'h1,
        AFSM_ERROR   = 2'h2,
        AFSM_UVLO    = 2'h3
    } afsm_cond_type;

    // Synchroniser depth, least two stages
    localparam int AFSM_SYNC_STAGES = 2;
    // Mode-select level selecting back-end auto-recovery
    localparam logic AFSM_MODE_SEL_LEVEL = 1'h0;
    // Reset values of synchronised lines: inactive high
    localparam logic AFSM_LINE_IDLE = 1'h1;
    // Bit positions inside the sampled line pair
    localparam int AFSM_BIT_WARN = 0;
    localparam int AFSM_BIT_SHUT = 1;

    // Status carried to the user side
    typedef struct packed {
        afsm_cond_type cond;        // Decoded condition
        logic          recovered;   // Pulse: shutdown released
        logic          faultEvent;  // Pulse: shutdown newly asserted
    } afsm_status_type;

endpackage : afsm_pkg

/* design/afsm_sync.sv */
/*
 * Multi-stage level synchroniser with clock enable.
 * Assumes the input is asynchronous; only the last stage is read outside.
 */
`timescale 1ns/10ps
module afsm_sync #(
    parameter int   STAGES    = 2,
    parameter logic RESET_VAL = 1'h1
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic clkEn,
    input  wire logic asyncIn,
    output logic      syncOut
);
    // Refuse too shallow a chain at elaboration
    if (STAGES < 2) begin : gBadDepth
        $error("afsm_sync: STAGES below 2");
    end

    typedef struct packed {
        logic [STAGES-1:0] chain;   // Shift chain
    } afsm_sync_state_type;

    afsm_sync_state_type state_q;   // Registered chain
    afsm_sync_state_type state_d;   // Next chain

    // Shift in a new sample each enabled cycle
    always_comb begin
        state_d = state_q;
        if (clkEn) begin
            state_d.chain = {state_q.chain[STAGES-2:0], asyncIn};
        end
    end

    // Register, reset to idle level
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= '{chain: {STAGES{RESET_VAL}}};
        end else begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.chain[STAGES-1];
endmodule : afsm_sync

/* dv/afsm_stage_model.sv */
/*
 * Output-stage model: N devices, each with open-drain warning and shutdown
 * pulls; a trip holds shutdown, then with modeSel at zero the device restarts on its own.
 * Assumes the bench resolves both wires with pull-ups.
 */
`timescale 1ns/10ps
module afsm_stage_model #(
    parameter int N   = 3,
    parameter int REC = 6
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [2:0]   modeSel,
    input  wire logic [N-1:0] hot,
    input  wire logic [N-1:0] trip,
    output logic      [N-1:0] warnPullEn,
    output logic      [N-1:0] shutPullEn
);
    int recCnt_q [N];  // Recovery countdown per device

    // Warning pulled low only, while the device runs hot
    assign warnPullEn = hot;

    // Trip holds shutdown; auto-recovery counts it down
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < N; i++) begin
            if (rst) begin
                recCnt_q[i] <= 0;
            end else if (trip[i]) begin
                recCnt_q[i] <= REC;
            end else if (recCnt_q[i] > 0 && modeSel == 3'h0) begin
                recCnt_q[i] <= recCnt_q[i] - 1;
            end
        end
    end

    // Shutdown pull, open-drain
    always_comb begin
        for (int i = 0; i < N; i++) begin
            shutPullEn[i] = (recCnt_q[i] > 0);
        end
    end
endmodule : afsm_stage_model

/* dv/test_amp_fault_status_monitor.sv */
/*
 * Bench for the fault-status monitor with a three-device stage model.
 * Assumes pull-ups on both lines; inputs change at falling edges.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_amp_fault_status_monitor;
    logic                      sys_clk, rst, clkEn;     // Clock, controls
    logic [2:0]                hot, trip, wPull, sPull; // Stage commands
    logic                      warnLine, shutLine;      // Resolved wires
    logic                      sel0, sel1, sel2, statusValid;
    afsm_pkg::afsm_status_type status;
    afsm_pkg::afsm_cond_type   held;                    // Frozen condition
    logic [1:0]                h0, h1, h2, h3;          // {warn,shut} history
    int                        runCnt, mismatches, total_checks;

    // Pull-ups: a wire is low if any device pulls
    assign warnLine = ~|wPull;
    assign shutLine = ~|sPull;

    afsm_monitor uut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .overtemp_warning_n(warnLine), .shutdown_fault_n(shutLine),
        .stage_mode_sel0(sel0), .stage_mode_sel1(sel1),
        .stage_mode_sel2(sel2), .status(status), .statusValid(statusValid));
    afsm_stage_model stages (.sys_clk(sys_clk), .rst(rst),
        .modeSel({sel2, sel1, sel0}), .hot(hot), .trip(trip),
        .warnPullEn(wPull), .shutPullEn(sPull));

    // Expected condition of a line pair
    function automatic afsm_pkg::afsm_cond_type dec(input logic [1:0] l);
        case (l)
            2'h0: return afsm_pkg::AFSM_ERROR;
            2'h1: return afsm_pkg::AFSM_WARNING;
            2'h2: return afsm_pkg::AFSM_UVLO;
            default: return afsm_pkg::AFSM_NORMAL;
        endcase
    endfunction : dec

    // Verdict and end of run
    task automatic end_sim();
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Valid must rise exactly after the synchroniser depth
    task automatic check_warmup();
        repeat (afsm_pkg::AFSM_SYNC_STAGES - 1) @(negedge sys_clk);
        `CHK("warmValid", 1'h0, statusValid)
        @(negedge sys_clk);
        `CHK("runValid", 1'h1, statusValid)
    endtask : check_warmup

    // Line history and count of enabled running edges
    always @(posedge sys_clk) begin
        h3 <= h2;
        h2 <= h1;
        h1 <= h0;
        h0 <= {warnLine, shutLine};
        runCnt <= (statusValid && clkEn && !rst) ? runCnt + 1 : 0;
    end

    // Per-cycle output checks, three-edge latency
    always @(negedge sys_clk) begin
        `CHK("modeSel", 3'h0, {sel0, sel1, sel2})
        if (runCnt >= 4) begin
            `CHK("cond", dec(h2), status.cond)
            `CHK("fault", h3[0] & ~h2[0], status.faultEvent)
            `CHK("recov", ~h3[0] & h2[0], status.recovered)
        end
    end

    // Clock
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Watchdog
    initial begin
        #40000;
        mismatches++;
        end_sim();
    end

    // Stimulus
    initial begin
        rst = 1'h1;
        clkEn = 1'h1;
        hot = 3'h0;
        trip = 3'h0;
        void'($urandom(32'hB01A));
        repeat (2) @(negedge sys_clk);
        rst = 1'h0;
        check_warmup();
        repeat (4) @(negedge sys_clk);
        // Corners: warning, error, undervoltage, staggered trips
        hot = 3'h4;
        repeat (6) @(negedge sys_clk);
        trip = 3'h1;
        @(negedge sys_clk);
        trip = 3'h0;
        repeat (3) @(negedge sys_clk);
        hot = 3'h0;
        trip = 3'h2;
        @(negedge sys_clk);
        trip = 3'h0;
        repeat (12) @(negedge sys_clk);
        // Random traffic
        for (int k = 0; k < 60; k++) begin
            hot = 3'($urandom());
            trip = ($urandom() & 1) ? 3'($urandom()) : 3'h0;
            @(negedge sys_clk);
            trip = 3'h0;
            repeat ($urandom_range(1, 8)) @(negedge sys_clk);
        end
        // Frozen clock enable keeps the condition
        clkEn = 1'h0;
        held = dec(h2);
        hot = ~hot;
        repeat (6) @(negedge sys_clk);
        `CHK("frozen", held, status.cond)
        `CHK("frozenPulse", 2'h0, {status.faultEvent, status.recovered})
        clkEn = 1'h1;
        repeat (8) @(negedge sys_clk);
        // Mid-run reset
        rst = 1'h1;
        repeat (2) @(negedge sys_clk);
        `CHK("valid", 1'h0, statusValid)
        `CHK("rstCond", afsm_pkg::AFSM_NORMAL, status.cond)
        rst = 1'h0;
        check_warmup();
        repeat (8) @(negedge sys_clk);
        end_sim();
    end
endmodule : test_amp_fault_status_monitor
